/* File: bench/cksp_host.sv */
`timescale 1ns/100ps
`default_nettype none
module cksp_host (
  input wire logic i_clk,
  input wire logic [3:0] i_bus,
  output logic o_strobe_n,
  output logic o_ale,
  output logic [3:0] o_nib
);
  logic [2:0] cnt_ff = 3'h0;
  initial begin
    o_strobe_n = 1'b1;
    o_nib = 4'hF;
  end
  always @(posedge i_clk) cnt_ff <= cnt_ff + 3'h1;
  assign o_ale = cnt_ff[2];
  task automatic cyc(input logic [3:0] a, d, output logic [3:0] r);
    @(posedge i_clk);
    o_strobe_n <= 1'b0;
    o_nib <= a;
    repeat (2) @(posedge i_clk);
    o_nib <= d;
    repeat (3) @(posedge i_clk);
    r = i_bus;
    o_strobe_n <= 1'b1;
    // nibble held until the rise is seen
    @(posedge i_clk);
    o_nib <= ~d;
    repeat (2) @(posedge i_clk);
  endtask : cyc
endmodule : cksp_host
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] sense = 8'h00;
  logic stb_n, ale, oe_n, idle;
  logic [3:0] hnib, dnib, bus;
  logic [15:0] drv;
  int num_errors = 0;
  int n_tests = 0;
  always #5 clk = ~clk;
  assign bus = oe_n ? hnib : dnib;
  cksp_host host_u (.i_clk(clk), .i_bus(bus), .o_strobe_n(stb_n),
    .o_ale(ale), .o_nib(hnib));
  cksp_top dut_u (.i_clk(clk), .i_nrst(nrst), .i_port_strobe_n(stb_n),
    .i_addr_latch(ale), .i_nibble_bus(bus), .i_sense_inputs(sense),
    .o_nibble_bus(dnib), .o_nibble_bus_oe_n(oe_n),
    .o_drive_lines(drv), .o_idle_drive_out(idle));
  task automatic chk(input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic rd(input logic [3:0] a, input logic [3:0] e);
    logic [3:0] r;
    host_u.cyc(a, ~e, r);
    chk(r, e);
    chk(oe_n, 1'b1);
  endtask : rd
  task automatic scan(input logic [3:0] a, v, input logic [7:0] s,
    input bit go);
    int n;
    logic [3:0] r;
    sense <= s;
    host_u.cyc(a, v, r);
    for (n = 0; n < 40 && drv === 16'h0000; n++) @(posedge clk);
    if (go) begin
      chk(drv, 16'h0001 << v);
      chk(idle, 1'b0);
      for (n = 0; n < 20 && drv !== 16'h0000; n++) @(posedge clk);
      chk(16'(n), 16'h0008);
      chk(idle, 1'b1);
      sense <= ~s;
    end else
      chk(drv, 16'h0000);
  endtask : scan
  task automatic t_all;
    for (int v = 0; v < 16; v++) begin
      scan({3'h2, v[0]}, 4'(v), {~4'(v), 4'(v)}, 1'b1);
      rd(4'h1, ~4'(v));
      rd(4'h0, 4'(v));
    end
    $display("test all lines done");
  endtask : t_all
  task automatic t_refuse;
    scan(4'h4, 4'h3, 8'hA5, 1'b1);
    scan(4'h4, 4'h5, 8'h3C, 1'b0);
    rd(4'h1, 4'hA);
    scan(4'h8, 4'h6, 8'h3C, 1'b0);
    scan(4'hC, 4'h6, 8'h3C, 1'b0);
    scan(4'h6, 4'h6, 8'h3C, 1'b0);
    scan(4'h5, 4'h9, 8'h81, 1'b1);
    rd(4'h0, 4'h1);
    $display("test refusals done");
  endtask : t_refuse
  task automatic test_done;
    $display("checks %0d errors %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_all();
    t_refuse();
    test_done();
  end
  initial begin
    #300000;
    num_errors++;
    test_done();
  end
endmodule : testbench
`default_nettype wire

/* File: hdl/cksp_top.sv */
// How it works
// - strobe fall latches address and instruction
// - write strobe rise captures scan value
// - value n drives line n only
// - zeroing until next latch strobe rise
// - drive starts at that latch fall
// - drive lasts one latch period exactly
// - sense byte latched at the latch fall that ends drive
// - idle drive high when no line driven
// - pressed key reads as one
// - read address 0 low nibble, 1 high nibble
// - latched byte held until read
// - writes ignored while data unread
// - writes accepted at address 4 or 5
// - read nibble driven while strobe low, until the clock after strobe rise
`timescale 1ns/100ps
`default_nettype none
module cksp_top (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_port_strobe_n,
  input wire logic i_addr_latch,
  input wire logic [3:0] i_nibble_bus,
  input wire logic [7:0] i_sense_inputs,
  output logic [3:0] o_nibble_bus,
  output logic o_nibble_bus_oe_n,
  output logic [15:0] o_drive_lines,
  output logic o_idle_drive_out
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ZERO, ST_WAIT_FALL, ST_DRIVE
  } cksp_state_t;

  cksp_state_t state_ff, nxt_state;
  logic strobe_ff, ale_ff;
  logic [1:0] addr_ff, nxt_addr;
  logic [1:0] instr_ff, nxt_instr;
  logic cyc_ff, nxt_cyc;
  logic [3:0] scan_ff, nxt_scan;
  logic [7:0] sense_ff, nxt_sense;
  logic full_ff, nxt_full;
  logic [15:0] drive_ff, nxt_drive;
  logic idle_ff, nxt_idle;
  cksp_pkg::cksp_nib_out_t nib_ff, nxt_nib;

  wire strobe_fall = strobe_ff && !i_port_strobe_n;
  wire strobe_rise = !strobe_ff && i_port_strobe_n;
  wire ale_rise = !ale_ff && i_addr_latch;
  wire ale_fall = ale_ff && !i_addr_latch;
  wire is_rd = instr_ff == cksp_pkg::INSTR_READ;
  wire wr_port = addr_ff == cksp_pkg::ADDR_LOW ||
    addr_ff == cksp_pkg::ADDR_HIGH;

  always_comb begin
    nxt_state = state_ff;
    nxt_addr = addr_ff;
    nxt_instr = instr_ff;
    nxt_cyc = cyc_ff;
    nxt_scan = scan_ff;
    nxt_sense = sense_ff;
    nxt_full = full_ff;
    nxt_drive = drive_ff;
    nxt_nib = nib_ff;
    if (strobe_fall) begin
      nxt_addr = i_nibble_bus[cksp_pkg::ADDR_LSB +: 2];
      nxt_instr = i_nibble_bus[cksp_pkg::INSTR_LSB +: 2];
      nxt_cyc = 1'b1;
    end
    // drive read nibble while strobe low
    if (cyc_ff && !i_port_strobe_n && is_rd) begin
      nxt_nib.oe_n = 1'b0;
      if (addr_ff == cksp_pkg::ADDR_LOW)
        nxt_nib.dout = sense_ff[3:0];
      else if (addr_ff == cksp_pkg::ADDR_HIGH)
        nxt_nib.dout = sense_ff[7:4];
      else
        nxt_nib.oe_n = 1'b1;
    end else if (i_port_strobe_n) begin
      nxt_nib.oe_n = 1'b1;
    end
    if (strobe_rise && cyc_ff) begin
      nxt_cyc = 1'b0;
      if (is_rd && wr_port)
        nxt_full = 1'b0;
    end
    unique case (state_ff)
      ST_IDLE: begin
        if (strobe_fall && !full_ff &&
            i_nibble_bus[cksp_pkg::INSTR_LSB +: 2] ==
              cksp_pkg::INSTR_WRITE &&
            !i_nibble_bus[cksp_pkg::ADDR_LSB + 1])
          nxt_state = ST_ADDR;
      end
      ST_ADDR: begin
        if (strobe_rise) begin
          nxt_scan = i_nibble_bus;
          nxt_state = ST_ZERO;
        end
      end
      ST_ZERO: begin
        // lines held off until latch rise
        if (ale_rise)
          nxt_state = ST_WAIT_FALL;
      end
      ST_WAIT_FALL: begin
        // one hot drive at latch fall
        if (ale_fall) begin
          nxt_drive = cksp_pkg::DRIVE_RST;
          nxt_drive[scan_ff] = 1'b1;
          nxt_state = ST_DRIVE;
        end
      end
      ST_DRIVE: begin
        if (ale_fall) begin
          nxt_drive = cksp_pkg::DRIVE_RST;
          nxt_sense = i_sense_inputs;
          nxt_full = 1'b1;
          nxt_state = ST_IDLE;
        end
      end
    endcase
    nxt_idle = ~|nxt_drive;
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= ST_IDLE;
      strobe_ff <= 1'b1;
      ale_ff <= 1'b0;
      addr_ff <= 2'h0;
      instr_ff <= 2'h3;
      cyc_ff <= 1'b0;
      scan_ff <= 4'h0;
      sense_ff <= cksp_pkg::SENSE_RST;
      full_ff <= 1'b0;
      drive_ff <= cksp_pkg::DRIVE_RST;
      idle_ff <= 1'b1;
      nib_ff <= '{dout: 4'h0, oe_n: 1'b1};
    end else begin
      state_ff <= nxt_state;
      strobe_ff <= i_port_strobe_n;
      ale_ff <= i_addr_latch;
      addr_ff <= nxt_addr;
      instr_ff <= nxt_instr;
      cyc_ff <= nxt_cyc;
      scan_ff <= nxt_scan;
      sense_ff <= nxt_sense;
      full_ff <= nxt_full;
      drive_ff <= nxt_drive;
      idle_ff <= nxt_idle;
      nib_ff <= nxt_nib;
    end
  end

  assign o_drive_lines = drive_ff;
  assign o_idle_drive_out = idle_ff;
  assign o_nibble_bus = nib_ff.dout;
  assign o_nibble_bus_oe_n = nib_ff.oe_n;

  zero_off_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_ff == ST_ZERO || state_ff == ST_ADDR) |-> drive_ff == 16'h0000)
    else $error("drive active during zeroing");
  one_hot_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    $rose(state_ff == ST_DRIVE) |-> drive_ff == (16'h0001 << scan_ff))
    else $error("wrong drive line");
  idle_inv_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    o_idle_drive_out == (o_drive_lines == 16'h0000))
    else $error("idle drive mismatch");
  // drive start and end steps
  sequence drive_go_s;
    state_ff == ST_WAIT_FALL && ale_fall;
  endsequence
  sequence drive_stop_s;
    state_ff == ST_DRIVE && ale_fall;
  endsequence
  drive_start_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    drive_go_s |=> drive_ff != 16'h0000)
    else $error("drive not started");
  drive_end_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    drive_stop_s |=> drive_ff == 16'h0000 && full_ff)
    else $error("drive not ended");
  sense_cap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    drive_stop_s |=> sense_ff == $past(i_sense_inputs))
    else $error("sense not latched");
  wr_block_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (state_ff == ST_IDLE && full_ff) |=> state_ff == ST_IDLE)
    else $error("write taken while full");
  rd_high_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (cyc_ff && is_rd && addr_ff == 2'h1 && !i_port_strobe_n)
      |=> !o_nibble_bus_oe_n && o_nibble_bus == $past(sense_ff[7:4]))
    else $error("high nibble wrong");
endmodule : cksp_top
`default_nettype wire

/* File: pkg/cksp_pkg.sv */
`default_nettype none
package cksp_pkg;
  localparam int NIB_W = 4;
  localparam int SENSE_W = 8;
  localparam int DRIVE_N = 16;
  // nibble bus field positions during address phase
  localparam int ADDR_LSB = 0;
  localparam int INSTR_LSB = 2;
  localparam logic [1:0] INSTR_READ = 2'h0;
  localparam logic [1:0] INSTR_WRITE = 2'h1;
  localparam logic [1:0] ADDR_LOW = 2'h0;
  localparam logic [1:0] ADDR_HIGH = 2'h1;
  localparam logic [15:0] DRIVE_RST = 16'h0000;
  localparam logic [7:0] SENSE_RST = 8'h00;

  typedef struct packed {
    logic [3:0] dout;
    logic oe_n;
  } cksp_nib_out_t;
endpackage : cksp_pkg
`default_nettype wire
